/* rtl/tmo_pkg.sv */
// Constants for the eight-bit timer one block: register map, fields, resets.
// Assumes an eight-bit register port decoded on the core clock.
package tmo_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] TMO_OFF_CLK_FLAGS = 8'hd8;
	localparam logic [7:0] TMO_OFF_MODE      = 8'hdc;
	localparam logic [7:0] TMO_OFF_COUNT     = 8'hdd;
	localparam logic [7:0] TMO_OFF_RELOAD    = 8'hde;
	localparam logic [7:0] TMO_OFF_IRQ_CTRL  = 8'hdf;

	// ---------------------------------------------------------------
	// Mode register fields
	// ---------------------------------------------------------------
	localparam int TMO_MODE_RUN_BIT   = 7;
	localparam int TMO_MODE_RATE_MSB  = 6;
	localparam int TMO_MODE_RATE_LSB  = 4;
	localparam int TMO_MODE_CKS_BIT   = 3;
	localparam int TMO_MODE_ALOAD_BIT = 2;
	localparam int TMO_MODE_BUZ_BIT   = 1;
	localparam int TMO_MODE_PWM_BIT   = 0;

	// ---------------------------------------------------------------
	// Clock select flags and interrupt control fields
	// ---------------------------------------------------------------
	localparam int         TMO_FLAGS_OSC_BIT  = 3;
	localparam logic [7:0] TMO_FLAGS_RW_MASK  = 8'h0e;
	localparam int         TMO_CTRL_OVF_BIT   = 0;
	localparam int         TMO_CTRL_IEN_BIT   = 1;
	localparam int         TMO_CTRL_PIN_BIT   = 2;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] TMO_RST_MODE   = 8'h00;
	localparam logic [7:0] TMO_RST_COUNT  = 8'h00;
	localparam logic [7:0] TMO_RST_RELOAD = 8'h00;
	localparam logic [7:0] TMO_RST_FLAGS  = 8'h00;

	// ---------------------------------------------------------------
	// Overflow boundaries and interrupt vector
	// ---------------------------------------------------------------
	localparam logic [7:0] TMO_BOUND_256 = 8'hff;
	localparam logic [7:0] TMO_BOUND_64  = 8'h3f;
	localparam logic [7:0] TMO_BOUND_32  = 8'h1f;
	localparam logic [7:0] TMO_BOUND_16  = 8'h0f;
	localparam logic [7:0] TMO_IRQ_VECTOR = 8'h08;

	// ---------------------------------------------------------------
	// Prescaler: divisor exponents at rate code zero
	// ---------------------------------------------------------------
	localparam logic [3:0] TMO_FCPU_EXP_MAX = 4'h8;
	localparam logic [3:0] TMO_HOSC_EXP_MAX = 4'h7;

	typedef enum logic [1:0] {
		TMO_PIN_GPIO   = 2'b00,
		TMO_PIN_PWM    = 2'b01,
		TMO_PIN_BUZZER = 2'b10
	} tmo_pin_sel_t;

endpackage : tmo_pkg

/* rtl/tmo_prescaler.sv */
// Prescaler for timer one: divides the instruction tick or the core clock.
// Assumes the instruction tick is a one-cycle pulse on the core clock.
`timescale 1ns/10ps
module tmo_prescaler #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_run,
	input  wire logic             i_osc_sel,
	input  wire logic [2:0]       i_rate,
	input  wire logic             i_fcpu_tick,
	output logic                  o_tick
);
	import tmo_pkg::*;

	generate
		if (WIDTH != 8) begin : g_bad_width
			$error("tmo_prescaler supports WIDTH 8 only");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Divisor selection
	// ---------------------------------------------------------------
	logic [WIDTH-1:0] div_q;
	logic [WIDTH-1:0] div_d;
	logic [3:0]       exp_sel;
	logic [WIDTH:0]   div_full;
	logic [WIDTH-1:0] div_mask;
	logic             base_en;

	assign exp_sel  = (i_osc_sel ? TMO_HOSC_EXP_MAX : TMO_FCPU_EXP_MAX) - {1'b0, i_rate};
	assign div_full = (9'h001 << exp_sel) - 9'h001;
	assign div_mask = div_full[WIDTH-1:0];
	assign base_en  = i_osc_sel ? 1'b1 : i_fcpu_tick;
	assign o_tick   = i_run & base_en & ((div_q & div_mask) == div_mask);
	assign div_d    = !i_run ? '0 : (base_en ? div_q + 8'h01 : div_q);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

endmodule : tmo_prescaler

/* rtl/tmo_timer_one.sv */
// Timer one: eight-bit up timer and event counter with reload, PWM and buzzer.
// Assumes a register port on the core clock and a port block that owns the pin.
`timescale 1ns/10ps
module tmo_timer_one (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic [7:0]       O_RDATA,
	input  wire logic        I_FCPU_TICK,
	input  wire logic        I_EVENT_PIN,
	input  wire logic        I_EVENT_PIN_EDGE,
	input  wire logic        I_GPIO_DOUT,
	input  wire logic        I_GPIO_OE_N,
	output logic             O_TIMER_OUT_PIN,
	output logic             O_TIMER_OUT_PIN_OE_N,
	output logic             O_OVERFLOW_IRQ,
	output logic [7:0]       O_IRQ_VECTOR,
	output logic             O_EVENT_PIN_IRQ_FLAG,
	output logic [1:0]       O_OTHER_CLK_FLAGS
);
	import tmo_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0]   mode_q;
	logic [7:0]   mode_d;
	logic [7:0]   flags_q;
	logic [7:0]   flags_d;
	logic [7:0]   count_q;
	logic [7:0]   count_d;
	logic [7:0]   hold_q;
	logic [7:0]   hold_d;
	logic [7:0]   active_q;
	logic [7:0]   active_d;
	logic         ovf_flag_q;
	logic         ovf_flag_d;
	logic         ien_q;
	logic         ien_d;
	logic         pin_flag_q;
	logic         pin_flag_d;
	logic         pwm_lvl_q;
	logic         pwm_lvl_d;
	logic         buzz_q;
	logic         buzz_d;
	logic         pin_out_q;
	logic         pin_out_d;
	logic         pin_oe_n_q;
	logic         pin_oe_n_d;
	logic [7:0]   rdata_q;
	logic [7:0]   rdata_d;
	logic         ev_meta_q;
	logic         ev_sync_q;
	logic         ev_last_q;

	// ---------------------------------------------------------------
	// Mode field decode
	// ---------------------------------------------------------------
	logic         run_en;
	logic [2:0]   rate;
	logic         ext_src;
	logic         reload_bit;
	logic         buzz_bit;
	logic         pwm_bit;
	logic         osc_sel;

	assign run_en     = mode_q[TMO_MODE_RUN_BIT];
	assign rate       = mode_q[TMO_MODE_RATE_MSB:TMO_MODE_RATE_LSB];
	assign ext_src    = mode_q[TMO_MODE_CKS_BIT];
	assign reload_bit = mode_q[TMO_MODE_ALOAD_BIT];
	assign buzz_bit   = mode_q[TMO_MODE_BUZ_BIT];
	assign pwm_bit    = mode_q[TMO_MODE_PWM_BIT];
	assign osc_sel    = flags_q[TMO_FLAGS_OSC_BIT];

	// ---------------------------------------------------------------
	// Register port decode
	// ---------------------------------------------------------------
	logic         wr_mode;
	logic         wr_flags;
	logic         wr_count;
	logic         wr_reload;
	logic         wr_ctrl;

	assign wr_mode   = I_WR & (I_ADDR == TMO_OFF_MODE);
	assign wr_flags  = I_WR & (I_ADDR == TMO_OFF_CLK_FLAGS);
	assign wr_count  = I_WR & (I_ADDR == TMO_OFF_COUNT);
	assign wr_reload = I_WR & (I_ADDR == TMO_OFF_RELOAD);
	assign wr_ctrl   = I_WR & (I_ADDR == TMO_OFF_IRQ_CTRL);

	// ---------------------------------------------------------------
	// Event pin synchroniser and falling edge
	// ---------------------------------------------------------------
	logic         ev_fall;

	assign ev_fall = ev_last_q & ~ev_sync_q;

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ev_meta_q <= 1'b1;
			ev_sync_q <= 1'b1;
			ev_last_q <= 1'b1;
		end else begin
			ev_meta_q <= I_EVENT_PIN;
			ev_sync_q <= ev_meta_q;
			ev_last_q <= ev_sync_q;
		end
	end

	// ---------------------------------------------------------------
	// Internal clock prescaler
	// ---------------------------------------------------------------
	logic         int_tick;

	tmo_prescaler #(
		.WIDTH       (8)
	) u_prescaler (
		.i_core_clk  (I_CORE_CLK),
		.i_run       (run_en & ~ext_src),
		.i_rst_n     (I_RST_N),
		.i_osc_sel   (osc_sel),
		.i_rate      (rate),
		.i_fcpu_tick (I_FCPU_TICK),
		.o_tick      (int_tick)
	);

	// ---------------------------------------------------------------
	// Count step, boundary and overflow
	// ---------------------------------------------------------------
	logic         count_tick;
	logic [7:0]   bound;
	logic         at_bound;
	logic         overflow;
	logic         reload_on;
	logic [7:0]   count_inc;

	// Rate and oscillator select only reach the prescaler path
	assign count_tick = run_en & (ext_src ? ev_fall : int_tick);

	assign bound = !pwm_bit ? TMO_BOUND_256 :
	               (!reload_bit && !buzz_bit) ? TMO_BOUND_256 :
	               (!reload_bit &&  buzz_bit) ? TMO_BOUND_64 :
	               ( reload_bit && !buzz_bit) ? TMO_BOUND_32 : TMO_BOUND_16;

	assign at_bound  = (count_q & bound) == bound;
	assign overflow  = count_tick & at_bound;
	assign reload_on = pwm_bit | reload_bit;
	assign count_inc = (count_q + 8'h01) & bound;

	// No low-power input gates the step: counting and outputs go on in green mode, and no wake request exists

	// ---------------------------------------------------------------
	// Next state of counter and reload buffers
	// ---------------------------------------------------------------
	always_comb begin
		count_d  = count_q;
		hold_d   = hold_q;
		active_d = active_q;
		if (wr_reload) begin
			hold_d = I_WDATA;
		end
		if (overflow) begin
			if (reload_on) begin
				count_d  = hold_q;
				active_d = hold_q;
			end else begin
				count_d = 8'h00;
			end
		end else if (count_tick) begin
			count_d = count_inc;
		end
		if (wr_count) begin
			count_d = I_WDATA;
		end
	end

	// ---------------------------------------------------------------
	// Flags: hardware set wins over software clear
	// ---------------------------------------------------------------
	logic         pin_irq_block;

	assign pin_irq_block = ext_src;
	assign ovf_flag_d = overflow | (wr_ctrl ? I_WDATA[TMO_CTRL_OVF_BIT] & ovf_flag_q : ovf_flag_q);
	assign ien_d      = wr_ctrl ? I_WDATA[TMO_CTRL_IEN_BIT] : ien_q;
	assign pin_flag_d = pin_irq_block ? 1'b0 :
	                    I_EVENT_PIN_EDGE | (wr_ctrl ? I_WDATA[TMO_CTRL_PIN_BIT] & pin_flag_q : pin_flag_q);
	assign mode_d     = wr_mode ? I_WDATA : mode_q;
	assign flags_d    = wr_flags ? (I_WDATA & TMO_FLAGS_RW_MASK) : flags_q;

	// ---------------------------------------------------------------
	// PWM level and buzzer toggle
	// ---------------------------------------------------------------
	logic         duty_match;

	assign duty_match = count_tick & ((count_inc & bound) == (active_q & bound));
	assign pwm_lvl_d  = overflow ? 1'b1 : (duty_match ? 1'b0 : pwm_lvl_q);
	assign buzz_d     = overflow ? ~buzz_q : buzz_q;

	// ---------------------------------------------------------------
	// Output pin selection
	// ---------------------------------------------------------------
	tmo_pin_sel_t pin_sel;

	assign pin_sel = pwm_bit ? TMO_PIN_PWM :
	                 buzz_bit ? TMO_PIN_BUZZER : TMO_PIN_GPIO;

	always_comb begin
		pin_out_d  = I_GPIO_DOUT;
		pin_oe_n_d = I_GPIO_OE_N;
		case (pin_sel)
			TMO_PIN_PWM: begin
				pin_out_d  = pwm_lvl_q;
				pin_oe_n_d = 1'b0;
			end
			TMO_PIN_BUZZER: begin
				pin_out_d  = buzz_q;
				pin_oe_n_d = 1'b0;
			end
			TMO_PIN_GPIO: begin
				pin_out_d  = I_GPIO_DOUT;
				pin_oe_n_d = I_GPIO_OE_N;
			end
			default: begin
				pin_out_d  = I_GPIO_DOUT;
				pin_oe_n_d = I_GPIO_OE_N;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	logic [7:0]   ctrl_view;

	assign ctrl_view = {5'h00, pin_flag_q, ien_q, ovf_flag_q};

	always_comb begin
		rdata_d = 8'h00;
		if (I_RD) begin
			case (I_ADDR)
				TMO_OFF_CLK_FLAGS: rdata_d = flags_q;
				TMO_OFF_MODE:      rdata_d = mode_q;
				TMO_OFF_COUNT:     rdata_d = count_q;
				TMO_OFF_IRQ_CTRL:  rdata_d = ctrl_view;
				default:           rdata_d = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mode_q   <= TMO_RST_MODE;
			flags_q  <= TMO_RST_FLAGS;
			count_q  <= TMO_RST_COUNT;
			hold_q   <= TMO_RST_RELOAD;
			active_q <= TMO_RST_RELOAD;
		end else begin
			mode_q   <= mode_d;
			flags_q  <= flags_d;
			count_q  <= count_d;
			hold_q   <= hold_d;
			active_q <= active_d;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ovf_flag_q <= 1'b0;
			ien_q      <= 1'b0;
			pin_flag_q <= 1'b0;
			pwm_lvl_q  <= 1'b1;
			buzz_q     <= 1'b0;
		end else begin
			ovf_flag_q <= ovf_flag_d;
			ien_q      <= ien_d;
			pin_flag_q <= pin_flag_d;
			pwm_lvl_q  <= pwm_lvl_d;
			buzz_q     <= buzz_d;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pin_out_q  <= 1'b0;
			pin_oe_n_q <= 1'b1;
			rdata_q    <= 8'h00;
		end else begin
			pin_out_q  <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
			rdata_q    <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign O_RDATA              = rdata_q;
	assign O_TIMER_OUT_PIN      = pin_out_q;
	assign O_TIMER_OUT_PIN_OE_N = pin_oe_n_q;
	assign O_OVERFLOW_IRQ       = ovf_flag_q & ien_q;
	assign O_IRQ_VECTOR         = TMO_IRQ_VECTOR;
	assign O_EVENT_PIN_IRQ_FLAG = pin_flag_q;
	assign O_OTHER_CLK_FLAGS    = flags_q[2:1];

endmodule : tmo_timer_one

/* verification/tmo_timer_one_assertions.sv */
// Checker for timer one: register port, flag and pin routing timing.
// Assumes it is bound to tmo_timer_one and runs on its core clock.
`timescale 1ns/10ps
module tmo_timer_one_assertions
	import tmo_pkg::*;
(
	input wire logic       I_CORE_CLK,
	input wire logic       I_RST_N,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic       I_WR,
	input wire logic       I_RD,
	input wire logic [7:0] O_RDATA,
	input wire logic       I_EVENT_PIN_EDGE,
	input wire logic       I_GPIO_DOUT,
	input wire logic       I_GPIO_OE_N,
	input wire logic       O_TIMER_OUT_PIN,
	input wire logic       O_TIMER_OUT_PIN_OE_N,
	input wire logic       O_OVERFLOW_IRQ,
	input wire logic [7:0] O_IRQ_VECTOR,
	input wire logic       O_EVENT_PIN_IRQ_FLAG
);
	logic       run_q, cks_q, out_q, hold_q;
	logic [7:0] cnt_q;
	wire        mode_wr = I_WR && I_ADDR == TMO_OFF_MODE;
	wire        ctrl_wr = I_WR && I_ADDR == TMO_OFF_IRQ_CTRL;
	wire        cnt_wr  = I_WR && I_ADDR == TMO_OFF_COUNT;

	// --------------------------------------------------------
	// Shadow of mode bits and last count written while stopped
	// --------------------------------------------------------
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			run_q  <= 1'b0;
			cks_q  <= 1'b0;
			out_q  <= 1'b0;
			hold_q <= 1'b0;
			cnt_q  <= 8'h00;
		end else begin
			if (mode_wr) begin
				run_q <= I_WDATA[TMO_MODE_RUN_BIT];
				cks_q <= I_WDATA[TMO_MODE_CKS_BIT];
				out_q <= I_WDATA[TMO_MODE_PWM_BIT] | I_WDATA[TMO_MODE_BUZ_BIT];
			end
			if (cnt_wr)
				cnt_q <= I_WDATA;
			if (mode_wr)
				hold_q <= 1'b0;
			else if (cnt_wr && !run_q)
				hold_q <= 1'b1;
		end
	end

	// --------------------------------------------------------
	// Properties
	// --------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_vec; O_IRQ_VECTOR == TMO_IRQ_VECTOR; endproperty
	a_vec: assert property (p_vec) else $error("irq vector not constant");
	property p_irq_off; ctrl_wr && !I_WDATA[TMO_CTRL_IEN_BIT] |=> !O_OVERFLOW_IRQ; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq high while disabled");
	property p_sticky; O_OVERFLOW_IRQ && !ctrl_wr |=> O_OVERFLOW_IRQ; endproperty
	a_sticky: assert property (p_sticky) else $error("overflow flag dropped alone");
	property p_reload_wo; I_RD && I_ADDR == TMO_OFF_RELOAD |=> O_RDATA == 8'h00; endproperty
	a_reload_wo: assert property (p_reload_wo) else $error("reload readable");
	property p_hold; hold_q && I_RD && I_ADDR == TMO_OFF_COUNT |=> O_RDATA == cnt_q; endproperty
	a_hold: assert property (p_hold) else $error("count moved while stopped");
	property p_stopped;
		!run_q && !$past(run_q) && !$past(run_q, 2) && !ctrl_wr && !$past(ctrl_wr) |-> !$rose(O_OVERFLOW_IRQ);
	endproperty
	a_stopped: assert property (p_stopped) else $error("overflow while stopped");
	property p_pin_quiet; cks_q && $past(cks_q) |-> !O_EVENT_PIN_IRQ_FLAG; endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("pin flag set in event mode");
	property p_pin_set; !cks_q && I_EVENT_PIN_EDGE && !I_WR |=> O_EVENT_PIN_IRQ_FLAG; endproperty
	a_pin_set: assert property (p_pin_set) else $error("pin flag not set");
	property p_gpio;
		!out_q && !$past(out_q) && $past(I_RST_N)
			|-> O_TIMER_OUT_PIN == $past(I_GPIO_DOUT) && O_TIMER_OUT_PIN_OE_N == $past(I_GPIO_OE_N);
	endproperty
	a_gpio: assert property (p_gpio) else $error("pin not back to gpio");
	property p_drive; run_q && out_q && $past(run_q) && $past(out_q) |-> !O_TIMER_OUT_PIN_OE_N; endproperty
	a_drive: assert property (p_drive) else $error("timer output not driven");
endmodule : tmo_timer_one_assertions

bind tmo_timer_one tmo_timer_one_assertions u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
	.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.I_EVENT_PIN_EDGE(I_EVENT_PIN_EDGE), .I_GPIO_DOUT(I_GPIO_DOUT), .I_GPIO_OE_N(I_GPIO_OE_N),
	.O_TIMER_OUT_PIN(O_TIMER_OUT_PIN), .O_TIMER_OUT_PIN_OE_N(O_TIMER_OUT_PIN_OE_N),
	.O_OVERFLOW_IRQ(O_OVERFLOW_IRQ), .O_IRQ_VECTOR(O_IRQ_VECTOR), .O_EVENT_PIN_IRQ_FLAG(O_EVENT_PIN_IRQ_FLAG));

/* verification/tmo_far_side.sv */
// Far side of timer one: event pulse source and output pin load.
// Assumes the block's core clock; the pulse source moves off the falling edge.
`timescale 1ns/10ps
module tmo_far_side (
	input  wire logic        i_clk,
	input  wire logic        i_pulse_en,
	input  wire logic        i_pin,
	input  wire logic        i_pin_oe_n,
	output logic             o_event_pin,
	output logic [15:0]      o_gap,
	output logic [15:0]      o_rises
);
	logic [15:0] cyc_q  = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] gap_q  = 16'h0000;
	logic [15:0] rise_q = 16'h0000;
	logic [4:0]  ph_q   = 5'h00;
	logic        pin_q  = 1'b0;
	logic        ev_q   = 1'b1;
	assign o_event_pin = ev_q;
	assign o_gap       = gap_q;
	assign o_rises     = rise_q;

	// --------------------------------------------------------
	// Pulled-up event pin, one falling edge every 20 cycles
	// --------------------------------------------------------
	always @(negedge i_clk) begin
		ph_q <= (ph_q == 5'd19) ? 5'h00 : ph_q + 5'h01;
		ev_q <= !(i_pulse_en && ph_q < 5'd10);
	end

	// --------------------------------------------------------
	// Load: cycles between rising edges of the driven pin
	// --------------------------------------------------------
	always @(posedge i_clk) begin
		cyc_q <= cyc_q + 16'h0001;
		pin_q <= i_pin;
		if (i_pin && !pin_q && !i_pin_oe_n) begin
			gap_q  <= cyc_q - last_q;
			last_q <= cyc_q;
			rise_q <= rise_q + 16'h0001;
		end
	end
endmodule : tmo_far_side

/* verification/tb_top.sv */
// Testbench for timer one: register tasks, rate, reload, flag and pin tests.
// Assumes the far-side model and the bound checker.
`timescale 1ns/10ps
module tb_top;
	import tmo_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fcpu = 1'b0, pedge = 1'b0;
	logic        gpio_d = 1'b0, gpio_oe_n = 1'b1, pulse_en = 1'b0, ev_pin;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, vec, lo, hi;
	logic        pin, pin_oe_n, irq, pflag;
	logic [1:0]  other;
	logic [2:0]  div_q = 3'h0;
	logic [15:0] gap, rises;
	int          miscompares = 0, n_checks = 0;

	tmo_timer_one DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .I_FCPU_TICK(fcpu), .I_EVENT_PIN(ev_pin), .I_EVENT_PIN_EDGE(pedge),
		.I_GPIO_DOUT(gpio_d), .I_GPIO_OE_N(gpio_oe_n), .O_TIMER_OUT_PIN(pin), .O_TIMER_OUT_PIN_OE_N(pin_oe_n),
		.O_OVERFLOW_IRQ(irq), .O_IRQ_VECTOR(vec), .O_EVENT_PIN_IRQ_FLAG(pflag), .O_OTHER_CLK_FLAGS(other));
	tmo_far_side u_far (.i_clk(clk), .i_pulse_en(pulse_en), .i_pin(pin), .i_pin_oe_n(pin_oe_n),
		.o_event_pin(ev_pin), .o_gap(gap), .o_rises(rises));

	always #2.5 clk = ~clk;
	// Instruction tick every 4 cycles, GPIO drive keeps moving
	always @(posedge clk) begin
		div_q     <= div_q + 3'h1;
		fcpu      <= (div_q[1:0] == 2'h3);
		gpio_d    <= div_q[0];
		gpio_oe_n <= div_q[2];
	end

	// --------------------------------------------------------
	// Tasks
	// --------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_get(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_get
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd_get(a, v);
		check("rdata", 16'(v), 16'(exp));
	endtask : rd_reg
	task automatic cfg(input logic osc, input logic [7:0] mode, input logic [7:0] cnt, input logic [7:0] rld);
		wr_reg(TMO_OFF_MODE, 8'h00);
		wr_reg(TMO_OFF_CLK_FLAGS, {4'h0, osc, 3'h0});
		wr_reg(TMO_OFF_COUNT, cnt);
		wr_reg(TMO_OFF_RELOAD, rld);
		wr_reg(TMO_OFF_MODE, mode & 8'h7f);
		wr_reg(TMO_OFF_MODE, mode);
	endtask : cfg
	task automatic period(input logic [15:0] exp);
		logic [15:0] r0;
		r0 = rises;
		// First rise after reconfiguring may still come from the GPIO level
		for (int i = 0; i < 40000 && rises < r0 + 16'd3; i++)
			@(posedge clk);
		#1 check("pin period", gap, exp);
	endtask : period
	task automatic scan();
		logic [7:0] v;
		lo = 8'hff;
		hi = 8'h00;
		repeat (300) begin
			rd_get(TMO_OFF_COUNT, v);
			if (v < lo) lo = v;
			if (v > hi) hi = v;
		end
	endtask : scan
	task automatic report_and_stop();
		$display("TB: %0d checks, %0d miscompares", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// --------------------------------------------------------
	// Tests
	// --------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(TMO_OFF_MODE, TMO_RST_MODE);
		rd_reg(TMO_OFF_COUNT, TMO_RST_COUNT);
		rd_reg(TMO_OFF_RELOAD, 8'h00);
		rd_reg(TMO_OFF_CLK_FLAGS, TMO_RST_FLAGS);
		rd_reg(TMO_OFF_IRQ_CTRL, 8'h00);
		rd_reg(8'hd0, 8'h00);
		wr_reg(TMO_OFF_CLK_FLAGS, 8'hff);
		rd_reg(TMO_OFF_CLK_FLAGS, TMO_FLAGS_RW_MASK);
		check("other flags", 16'(other), 16'h0003);
		wr_reg(TMO_OFF_MODE, 8'h5a);
		rd_reg(TMO_OFF_MODE, 8'h5a);
		wr_reg(TMO_OFF_COUNT, 8'ha5);
		repeat (20) @(posedge clk);
		rd_reg(TMO_OFF_COUNT, 8'ha5);
		$display("test registers done");
		for (int r = 0; r < 8; r++) begin
			cfg(1'b1, 8'h86 | 8'(r << 4), 8'hfc, 8'hfc);
			period(16'(8 << (7 - r)));
			cfg(1'b0, 8'h86 | 8'(r << 4), 8'hfc, 8'hfc);
			period(16'(32 << (8 - r)));
		end
		cfg(1'b1, 8'hf2, 8'h00, 8'hf0);
		period(16'd512);
		cfg(1'b1, 8'hf6, 8'hfc, 8'hfc);
		wr_reg(TMO_OFF_RELOAD, 8'hf8);
		period(16'd16);
		$display("test rates and reload done");
		for (int p = 0; p < 4; p++) begin
			cfg(1'b1, 8'he1 | 8'(p << 1), 8'h00, 8'h00);
			scan();
			check("pwm top", 16'(hi), 16'(8'hff >> (p == 0 ? 0 : p + 1)));
		end
		cfg(1'b1, 8'he1, 8'hf8, 8'hf8);
		scan();
		check("pwm floor", 16'(lo), 16'h00f8);
		cfg(1'b1, 8'hd1, 8'h00, 8'hf8);
		repeat (900) @(posedge clk);
		#1 check("pwm start", 16'(pin), 16'h0001);
		check("pwm drive", 16'(pin_oe_n), 16'h0000);
		repeat (108) @(posedge clk);
		#1 check("pwm match", 16'(pin), 16'h0000);
		repeat (92) @(posedge clk);
		#1 check("pwm wrap", 16'(pin), 16'h0001);
		$display("test pwm done");
		pulse_en <= 1'b1;
		cfg(1'b1, 8'hfe, 8'hfe, 8'hfe);
		period(16'd80);
		pulse_en <= 1'b0;
		wr_reg(TMO_OFF_MODE, 8'h00);
		wr_reg(TMO_OFF_IRQ_CTRL, 8'h02);
		rd_reg(TMO_OFF_IRQ_CTRL, 8'h02);
		check("irq", 16'(irq), 16'h0000);
		cfg(1'b1, 8'hf6, 8'hfc, 8'hfc);
		repeat (20) @(posedge clk);
		wr_reg(TMO_OFF_MODE, 8'h00);
		repeat (20) @(posedge clk);
		rd_reg(TMO_OFF_IRQ_CTRL, 8'h03);
		check("irq", 16'(irq), 16'h0001);
		check("vector", 16'(vec), 16'h0008);
		wr_reg(TMO_OFF_IRQ_CTRL, 8'h03);
		rd_reg(TMO_OFF_IRQ_CTRL, 8'h03);
		wr_reg(TMO_OFF_IRQ_CTRL, 8'h00);
		rd_reg(TMO_OFF_IRQ_CTRL, 8'h00);
		@(posedge clk);
		pedge <= 1'b1;
		@(posedge clk);
		pedge <= 1'b0;
		rd_reg(TMO_OFF_IRQ_CTRL, 8'h04);
		wr_reg(TMO_OFF_MODE, 8'h08);
		repeat (3) @(posedge clk);
		check("pin flag", 16'(pflag), 16'h0000);
		pedge <= 1'b1;
		@(posedge clk);
		pedge <= 1'b0;
		rd_reg(TMO_OFF_IRQ_CTRL, 8'h00);
		wr_reg(TMO_OFF_MODE, 8'h00);
		repeat (10) @(posedge clk);
		$display("test flags done");
		report_and_stop();
	end

	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
endmodule : tb_top
